// File: core/rx_cfg_consts.svh
/*
 Register offsets, field positions, reset values and timing figures
 for the receiver configuration block.
 Assumes a 20 MHz system clock; included by its bare name.
*/
`ifndef RX_CFG_CONSTS_SVH
`define RX_CFG_CONSTS_SVH

// Register offsets on the serial register port
`define ADDR_FRF_LSB 7'h09
`define ADDR_OSC 7'h0a
`define ADDR_AFC 7'h0b
`define ADDR_LOWBAT 7'h0c
`define ADDR_LISTEN1 7'h0d
`define ADDR_LISTEN2 7'h0e
`define ADDR_LISTEN3 7'h0f

// Field positions
`define OSC_CAL_START 7
`define OSC_CAL_DONE 6
`define AFC_LOW_INDEX 5
`define LB_LIVE 4
`define LB_ENABLE 3
`define LB_TRIM_LSB 0
`define LS_IDLE_LSB 6
`define LS_RX_LSB 4
`define LS_CRIT 3
`define LS_END_LSB 1

// Reset values
`define RST_FRF_LSB 8'h00
`define RST_AFC_LOW 1'b0
`define RST_LB_EN 1'b0
`define RST_LB_TRIM 3'h2
`define RST_IDLE_BASE 2'h2
`define RST_RX_BASE 2'h1
`define RST_CRIT 1'b0
`define RST_END 2'h1
`define RST_IDLE_COEF 8'hf5
`define RST_RX_COEF 8'h20

// Timing figures in microseconds, clock rate in MHz
`define CLK_MHZ 20
`define TB_SHORT_US 64
`define TB_MID_US 4100
`define TB_LONG_US 262000
`define CAL_TIME_US 5

`endif

// File: core/rx_cfg_pkg.sv
/*
 Types shared by the receiver configuration block.
 Assumes nothing of its surroundings.
*/
package rx_cfg_pkg;
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_SYNTH = 3'b010,
		MODE_RX = 3'b100
	} chip_mode_e;
	typedef enum logic [2:0] {
		LS_OFF = 3'b000,
		LS_IDLE = 3'b001,
		LS_RX = 3'b010,
		LS_HOLD = 3'b011,
		LS_STOP = 3'b100
	} listen_state_e;
	typedef enum logic [1:0] {
		END_STAY = 2'b00,
		END_TO_MODE = 2'b01,
		END_RESUME = 2'b10
	} end_action_e;
endpackage

// File: core/timebase_link_if.sv
/*
 Link between the register block and the RC time base unit.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface timebase_link_if;
	logic calStart;
	logic calDone;
	logic [1:0] baseCode;
	logic baseRestart;
	logic unitTick;
	modport regs (output calStart, output baseCode, output baseRestart,
		input calDone, input unitTick);
	modport unit (input calStart, input baseCode, input baseRestart,
		output calDone, output unitTick);
endinterface

// File: core/rc_timebase.sv
/*
 RC oscillator calibration timer and listen time base tick generator.
 Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ns
`include "rx_cfg_consts.svh"
module rc_timebase #(
	parameter int unsigned MID_CYCLES = `TB_MID_US * `CLK_MHZ,
	parameter int unsigned LONG_CYCLES = `TB_LONG_US * `CLK_MHZ,
	parameter int unsigned CAL_CYCLES = `CAL_TIME_US * `CLK_MHZ
) (
	input wire logic mclk,
	input wire logic rstInt_n,
	timebase_link_if.unit lnk
);
	localparam logic [22:0] SHORT_CYCLES = 23'(`TB_SHORT_US * `CLK_MHZ);

	logic [22:0] baseCnt;
	logic [15:0] calCnt;

	// Unit length per code; code 00 is reserved and falls back to the shortest
	function automatic logic [22:0] baseCycles(input logic [1:0] code);
		case (code)
			2'h2: baseCycles = MID_CYCLES[22:0];
			2'h3: baseCycles = LONG_CYCLES[22:0];
			default: baseCycles = SHORT_CYCLES;
		endcase
	endfunction

	wire [22:0] unitLen = baseCycles(lnk.baseCode);
	wire unitEnd = (baseCnt == unitLen - 23'h1);

	// One-cycle tick at the end of every time base unit
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			baseCnt <= 23'h0;
			lnk.unitTick <= 1'b0;
		end else if (lnk.baseRestart) begin
			baseCnt <= 23'h0;
			lnk.unitTick <= 1'b0;
		end else begin
			baseCnt <= unitEnd ? 23'h0 : baseCnt + 23'h1;
			lnk.unitTick <= unitEnd;
		end
	end

	// Calibration runs a fixed count; done drops the cycle after a start
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			calCnt <= 16'h0;
			lnk.calDone <= 1'b1;
		end else if (lnk.calStart) begin
			calCnt <= CAL_CYCLES[15:0] - 16'h1;
			lnk.calDone <= 1'b0;
		end else if (!lnk.calDone) begin
			calCnt <= calCnt - 16'h1;
			lnk.calDone <= (calCnt == 16'h0);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstInt_n);

	cal_done_drop_a: assert property (lnk.calStart |=> !lnk.calDone)
		else $error("calibration done did not drop after start");
	cal_done_end_a: assert property (
		!lnk.calDone && !lnk.calStart && calCnt == 16'h0 |=> lnk.calDone)
		else $error("calibration done did not return");
endmodule

// File: core/rx_osc_lowbat_listen_config.sv
/*
 Configuration and status registers for the oscillator, AFC, low
 battery detector and listen mode, reached over the serial register
 port, plus the listen cycling controller they steer.
 Assumes the serial pins and detector inputs are synchronous to mclk.
*/
`timescale 1ns/1ns
`include "rx_cfg_consts.svh"
module rx_osc_lowbat_listen_config #(
	parameter int unsigned MID_CYCLES = `TB_MID_US * `CLK_MHZ,
	parameter int unsigned LONG_CYCLES = `TB_LONG_US * `CLK_MHZ,
	parameter int unsigned CAL_CYCLES = `CAL_TIME_US * `CLK_MHZ
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic spiSel_n,
	output logic miso,
	output logic misoOe,
	input wire logic supplyDetectorOut,
	input wire logic listenOn,
	input wire logic [2:0] modeSelect,
	input wire logic rssiAbove,
	input wire logic syncAddressMatch,
	input wire logic packetCompleteFlag,
	input wire logic rxTimeout,
	output logic [7:0] carrierFreqLow,
	output logic afcLowIndexSelect,
	output logic supplyDetectorEnable,
	output logic [2:0] supplyThresholdTrim,
	output logic [2:0] chipMode,
	output logic discardBuffer,
	output logic listenStopped
);
	logic [1:0] rstSync;
	wire rstInt_n = rstSync[1];

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end

	timebase_link_if lnk();

	rc_timebase #(
		.MID_CYCLES(MID_CYCLES),
		.LONG_CYCLES(LONG_CYCLES),
		.CAL_CYCLES(CAL_CYCLES)
	) timebase (
		.mclk(mclk),
		.rstInt_n(rstInt_n),
		.lnk(lnk)
	);

	// Serial port state: first byte is write flag plus address
	logic sckPrev;
	logic [2:0] bitCnt;
	logic addrPhase;
	logic writeAccess;
	logic [6:0] regAddr;
	logic [7:0] inShift;
	logic [7:0] outShift;

	// Register contents
	logic [1:0] idleBase;
	logic [1:0] rxBase;
	logic criterion;
	logic [1:0] endAction;
	logic [7:0] idleCoef;
	logic [7:0] rxCoef;
	logic calStartPulse;
	logic supplyLowLive;

	// Edge and byte decode
	wire sckRise = !spiSel_n && sck && !sckPrev;
	wire sckFall = !spiSel_n && !sck && sckPrev;
	wire byteDone = sckRise && (bitCnt == 3'h7);
	wire [7:0] byteIn = {inShift[6:0], mosi};
	wire regWrite = byteDone && !addrPhase && writeAccess;
	wire [6:0] nextAddr = addrPhase ? byteIn[6:0] : regAddr + 7'h01;

	// Address decode for the write path
	wire hitFrf = regWrite && (regAddr == `ADDR_FRF_LSB);
	wire hitOsc = regWrite && (regAddr == `ADDR_OSC);
	wire hitAfc = regWrite && (regAddr == `ADDR_AFC);
	wire hitLowBat = regWrite && (regAddr == `ADDR_LOWBAT);
	wire hitListen1 = regWrite && (regAddr == `ADDR_LISTEN1);
	wire hitListen2 = regWrite && (regAddr == `ADDR_LISTEN2);
	wire hitListen3 = regWrite && (regAddr == `ADDR_LISTEN3);

	// Read view of each register; start bit and unused bits read zero
	function automatic logic [7:0] regRead(input logic [6:0] addr);
		case (addr)
			`ADDR_FRF_LSB: regRead = carrierFreqLow;
			`ADDR_OSC: regRead = {1'b0, lnk.calDone, 6'h00};
			`ADDR_AFC: regRead = {2'h0, afcLowIndexSelect, 5'h00};
			`ADDR_LOWBAT: regRead = {3'h0, supplyLowLive, supplyDetectorEnable,
				supplyThresholdTrim};
			`ADDR_LISTEN1: regRead = {idleBase, rxBase, criterion, endAction, 1'b0};
			`ADDR_LISTEN2: regRead = idleCoef;
			`ADDR_LISTEN3: regRead = rxCoef;
			default: regRead = 8'h00;
		endcase
	endfunction

	wire [7:0] readData = regRead(nextAddr);

	// Serial framing; deselect restarts at the address byte
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			sckPrev <= 1'b0;
			bitCnt <= 3'h0;
			addrPhase <= 1'b1;
			writeAccess <= 1'b0;
			regAddr <= 7'h00;
			inShift <= 8'h00;
		end else if (spiSel_n) begin
			sckPrev <= sck;
			bitCnt <= 3'h0;
			addrPhase <= 1'b1;
		end else begin
			sckPrev <= sck;
			if (sckRise) begin
				bitCnt <= bitCnt + 3'h1;
				inShift <= byteIn;
			end
			if (byteDone) begin
				addrPhase <= 1'b0;
				regAddr <= nextAddr; // Burst moves to the next address
				if (addrPhase) begin
					writeAccess <= byteIn[7];
				end
			end
		end
	end

	// Read data loads at each byte end and shifts out on falling edges
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			outShift <= 8'h00;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			misoOe <= !spiSel_n;
			if (byteDone) begin
				outShift <= readData;
			end else if (sckFall) begin
				miso <= outShift[7];
				outShift <= {outShift[6:0], 1'b0};
			end
		end
	end

	// Register writes; writes to read-only bits are dropped
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			carrierFreqLow <= `RST_FRF_LSB;
			afcLowIndexSelect <= `RST_AFC_LOW;
			supplyDetectorEnable <= `RST_LB_EN;
			supplyThresholdTrim <= `RST_LB_TRIM;
			idleBase <= `RST_IDLE_BASE;
			rxBase <= `RST_RX_BASE;
			criterion <= `RST_CRIT;
			endAction <= `RST_END;
			idleCoef <= `RST_IDLE_COEF;
			rxCoef <= `RST_RX_COEF;
			calStartPulse <= 1'b0;
		end else begin
			calStartPulse <= hitOsc && byteIn[`OSC_CAL_START];
			if (hitFrf) carrierFreqLow <= byteIn;
			if (hitAfc) afcLowIndexSelect <= byteIn[`AFC_LOW_INDEX];
			if (hitLowBat) begin
				supplyDetectorEnable <= byteIn[`LB_ENABLE];
				supplyThresholdTrim <= byteIn[`LB_TRIM_LSB +: 3];
			end
			if (hitListen1) begin
				idleBase <= byteIn[`LS_IDLE_LSB +: 2];
				rxBase <= byteIn[`LS_RX_LSB +: 2];
				criterion <= byteIn[`LS_CRIT];
				endAction <= byteIn[`LS_END_LSB +: 2];
			end
			if (hitListen2) idleCoef <= byteIn;
			if (hitListen3) rxCoef <= byteIn;
		end
	end

	// Detector output is passed through live, never latched
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			supplyLowLive <= 1'b0;
		end else begin
			supplyLowLive <= supplyDetectorEnable && supplyDetectorOut;
		end
	end

	// Listen cycling controller
	rx_cfg_pkg::listen_state_e state;
	rx_cfg_pkg::listen_state_e next_state;
	logic [7:0] unitsLeft;
	logic stopToMode;
	logic discardPending;
	logic [2:0] next_chipMode;

	wire accept = rssiAbove && (!criterion || syncAddressMatch);
	wire endEvent = packetCompleteFlag || rxTimeout;
	wire phaseEnd = (unitsLeft == 8'h00) || (lnk.unitTick && unitsLeft == 8'h01);
	wire phaseEntry = (next_state != state) &&
		(next_state == rx_cfg_pkg::LS_IDLE || next_state == rx_cfg_pkg::LS_RX);

	assign lnk.calStart = calStartPulse;
	assign lnk.baseCode = (state == rx_cfg_pkg::LS_IDLE) ? idleBase : rxBase;
	assign lnk.baseRestart = phaseEntry;

	// Next state; dropping the listen enable always returns to off
	always_comb begin
		next_state = state;
		case (state)
			rx_cfg_pkg::LS_OFF: if (listenOn) next_state = rx_cfg_pkg::LS_IDLE;
			rx_cfg_pkg::LS_IDLE: if (phaseEnd) next_state = rx_cfg_pkg::LS_RX;
			rx_cfg_pkg::LS_RX: begin
				if (accept && endAction == rx_cfg_pkg::END_STAY) begin
					next_state = rx_cfg_pkg::LS_STOP;
				end else if (accept) begin
					next_state = rx_cfg_pkg::LS_HOLD;
				end else if (phaseEnd) begin
					next_state = rx_cfg_pkg::LS_IDLE;
				end
			end
			rx_cfg_pkg::LS_HOLD: begin
				if (endEvent && endAction == rx_cfg_pkg::END_RESUME) begin
					next_state = rx_cfg_pkg::LS_IDLE;
				end else if (endEvent) begin
					next_state = rx_cfg_pkg::LS_STOP;
				end
			end
			rx_cfg_pkg::LS_STOP: next_state = rx_cfg_pkg::LS_STOP;
			default: next_state = rx_cfg_pkg::LS_OFF;
		endcase
		if (!listenOn) next_state = rx_cfg_pkg::LS_OFF;
	end

	// Chip mode follows the listen phase, else the selected mode
	always_comb begin
		case (next_state)
			rx_cfg_pkg::LS_IDLE: next_chipMode = rx_cfg_pkg::MODE_SLEEP;
			rx_cfg_pkg::LS_RX: next_chipMode = rx_cfg_pkg::MODE_RX;
			rx_cfg_pkg::LS_HOLD: next_chipMode = rx_cfg_pkg::MODE_RX;
			rx_cfg_pkg::LS_STOP: begin
				if (stopToMode || state == rx_cfg_pkg::LS_HOLD) begin
					next_chipMode = modeSelect;
				end else begin
					next_chipMode = rx_cfg_pkg::MODE_RX;
				end
			end
			default: next_chipMode = modeSelect;
		endcase
	end

	// Phase units count down; each phase reloads its own coefficient
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			state <= rx_cfg_pkg::LS_OFF;
			unitsLeft <= 8'h00;
			chipMode <= rx_cfg_pkg::MODE_STANDBY;
			listenStopped <= 1'b0;
			stopToMode <= 1'b0;
		end else begin
			state <= next_state;
			chipMode <= next_chipMode;
			listenStopped <= (next_state == rx_cfg_pkg::LS_STOP);
			if (next_state == rx_cfg_pkg::LS_STOP && state == rx_cfg_pkg::LS_HOLD) begin
				stopToMode <= 1'b1;
			end else if (next_state != rx_cfg_pkg::LS_STOP) begin
				stopToMode <= 1'b0;
			end
			if (phaseEntry) begin
				unitsLeft <= (next_state == rx_cfg_pkg::LS_IDLE) ? idleCoef : rxCoef;
			end else if (lnk.unitTick && unitsLeft != 8'h00) begin
				unitsLeft <= unitsLeft - 8'h01;
			end
		end
	end

	// Buffer is discarded at the first receive wakeup after a resume
	always_ff @(posedge mclk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			discardPending <= 1'b0;
			discardBuffer <= 1'b0;
		end else begin
			discardBuffer <= discardPending && phaseEntry &&
				next_state == rx_cfg_pkg::LS_RX;
			if (state == rx_cfg_pkg::LS_HOLD && next_state == rx_cfg_pkg::LS_IDLE) begin
				discardPending <= 1'b1;
			end else if (next_state == rx_cfg_pkg::LS_OFF || discardBuffer) begin
				discardPending <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstInt_n);

	afc_select_a: assert property (
		hitAfc |=> afcLowIndexSelect == $past(byteIn[`AFC_LOW_INDEX]))
		else $error("AFC routine select did not follow write");
	cal_start_a: assert property (
		hitOsc && byteIn[`OSC_CAL_START] |=> ##1 !lnk.calDone)
		else $error("calibration write did not start calibration");
	start_reads_zero_a: assert property (
		byteDone && nextAddr == `ADDR_OSC |=> !outShift[7])
		else $error("calibration start bit read back as one");
	live_detector_a: assert property (
		supplyDetectorEnable && supplyDetectorOut ##1 supplyDetectorEnable |-> supplyLowLive)
		else $error("detector output not shown live");
	detector_off_a: assert property (
		!supplyDetectorEnable ##1 !supplyDetectorEnable |-> !supplyLowLive)
		else $error("detector reports while disabled");
	idle_sleep_a: assert property (
		state == rx_cfg_pkg::LS_IDLE |-> chipMode == rx_cfg_pkg::MODE_SLEEP)
		else $error("idle phase not in sleep");
	rx_phase_a: assert property (
		state == rx_cfg_pkg::LS_RX && !accept && phaseEnd && listenOn
		|=> state == rx_cfg_pkg::LS_IDLE && unitsLeft == $past(idleCoef))
		else $error("receive phase did not hand over to idle");
	stay_rx_a: assert property (
		state == rx_cfg_pkg::LS_RX && accept && endAction == 2'h0 && listenOn
		|=> listenStopped && chipMode == rx_cfg_pkg::MODE_RX)
		else $error("end code 00 did not hold receive");
	to_mode_a: assert property (
		state == rx_cfg_pkg::LS_HOLD && endEvent && endAction == 2'h1 && listenOn
		|=> listenStopped && chipMode == $past(modeSelect))
		else $error("end code 01 did not enter selected mode");
	resume_idle_a: assert property (
		state == rx_cfg_pkg::LS_HOLD && endEvent && endAction == 2'h2 && listenOn
		|=> state == rx_cfg_pkg::LS_IDLE && discardPending)
		else $error("end code 10 did not resume idle");
endmodule

// File: sim/spi_host_model.sv
/*
 Host side of the serial register port: frames and bytes, MSB first.
 Assumes mclk is the device clock; the host moves its pins on its falling edge.
*/
`timescale 1ns/1ns
module spi_host_model (
	input wire logic mclk,
	output logic sck,
	output logic mosi,
	output logic spiSel_n,
	input wire logic miso
);
	// Idle: clock low, deselected
	initial begin
		sck = 1'b0;
		mosi = 1'b1;
		spiSel_n = 1'b1;
	end

	// Three clocks per phase keep the two-clock minimum with margin for the late miso
	task automatic shiftByte(input logic [7:0] txd, output logic [7:0] rxd);
		for (int i = 7; i >= 0; i--) begin
			mosi = txd[i];
			repeat (3) @(negedge mclk);
			rxd[i] = miso; // Settled value just before the rise
			sck = 1'b1;
			repeat (3) @(negedge mclk);
			sck = 1'b0;
		end
	endtask

	// One frame: command byte then one data byte
	task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [7:0] dummy;
		@(negedge mclk);
		spiSel_n = 1'b0;
		repeat (2) @(negedge mclk);
		shiftByte({wr, addr}, dummy);
		shiftByte(wdata, rdata);
		repeat (2) @(negedge mclk);
		spiSel_n = 1'b1;
		mosi = ~mosi; // Released line shows the inverse, never the last bit
		repeat (2) @(negedge mclk);
	endtask
endmodule

// File: sim/rx_osc_lowbat_listen_config_test.sv
/*
 Self-checking bench for the receiver configuration block.
 Assumes the host model above drives the serial port; shortened time bases.
*/
`timescale 1ns/1ns
module rx_osc_lowbat_listen_config_test;
	localparam int unsigned MID = 40;
	localparam int unsigned CAL = 400;
	localparam int unsigned SHORT = 1280; // 64 us unit, not shortened in the design
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sck, mosi, spiSel_n, miso, misoOe, supplyDetectorOut, listenOn;
	logic rssiAbove, syncAddressMatch, packetCompleteFlag, rxTimeout;
	logic afcLowIndexSelect, supplyDetectorEnable, discardBuffer, listenStopped;
	logic [2:0] modeSelect, supplyThresholdTrim, chipMode;
	logic [7:0] carrierFreqLow, got;
	logic [31:0] rnd;
	logic oeWant = 1'b0;
	int seed = 32'h60e4;
	int mismatches = 0;
	int checkCount = 0;
	int discards = 0;
	int n;
	int idleUnit;
	logic [7:0] regModel [128]; // Expected read value per address
	logic [7:0] writeMask [128]; // Writable bits per address; zero where unmapped

	rx_osc_lowbat_listen_config #(.MID_CYCLES(MID), .LONG_CYCLES(2 * MID),
		.CAL_CYCLES(CAL)) u_rx_osc_lowbat_listen_config (.mclk(mclk), .rst_n(rst_n),
		.sck(sck), .mosi(mosi), .spiSel_n(spiSel_n), .miso(miso), .misoOe(misoOe),
		.supplyDetectorOut(supplyDetectorOut), .listenOn(listenOn), .modeSelect(modeSelect),
		.rssiAbove(rssiAbove), .syncAddressMatch(syncAddressMatch),
		.packetCompleteFlag(packetCompleteFlag), .rxTimeout(rxTimeout),
		.carrierFreqLow(carrierFreqLow), .afcLowIndexSelect(afcLowIndexSelect),
		.supplyDetectorEnable(supplyDetectorEnable), .supplyThresholdTrim(supplyThresholdTrim),
		.chipMode(chipMode), .discardBuffer(discardBuffer), .listenStopped(listenStopped));

	spi_host_model u_spi_host_model (.mclk(mclk), .sck(sck), .mosi(mosi),
		.spiSel_n(spiSel_n), .miso(miso));

	// Clock, discard pulse counter and output enable follower, sampled off the launch edge
	always #25 mclk = ~mclk;
	always @(negedge mclk) if (discardBuffer === 1'b1) discards++;
	always @(posedge mclk) oeWant <= !spiSel_n;
	always @(negedge mclk) check("misoOe", {7'h0, misoOe}, {7'h0, oeWant});

	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		checkCount++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask

	// Register traffic keeps the bench model in step
	task automatic regWrite(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		u_spi_host_model.access(1'b1, addr, data, unused);
		regModel[addr] = (regModel[addr] & ~writeMask[addr]) | (data & writeMask[addr]);
	endtask

	task automatic regCheck(input logic [6:0] addr);
		logic [7:0] rd;
		u_spi_host_model.access(1'b0, addr, 8'h00, rd);
		check($sformatf("reg %h", addr), rd, regModel[addr]);
	endtask

	// Bounded wait for a chip mode; running out ends the run
	task automatic waitMode(input logic [2:0] m, input int bound, output int cnt);
		cnt = 0;
		while (chipMode !== m) begin
			@(negedge mclk);
			cnt++;
			if (cnt > bound) begin
				check("mode wait", {5'h0, chipMode}, {5'h0, m});
				conclude();
			end
		end
	endtask

	initial begin
		for (int a = 0; a < 128; a++) {regModel[a], writeMask[a]} = 16'h0000;
		{regModel[10], regModel[12], regModel[13], regModel[14], regModel[15]} =
			40'h40_02_92_f5_20;
		{writeMask[9], writeMask[11], writeMask[12], writeMask[13], writeMask[14],
			writeMask[15]} = 48'hff_20_0f_fe_ff_ff;
		// The serial clock belongs to the host model alone
		{supplyDetectorOut, listenOn, rssiAbove, syncAddressMatch} = 4'h0;
		{packetCompleteFlag, rxTimeout} = 2'h0;
		modeSelect = 3'b001;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		// Reset state at the pins and in every register
		check("chipMode", {5'h0, chipMode}, 8'h01);
		check("trim", {5'h0, supplyThresholdTrim}, 8'h02);
		check("detEn", {7'h0, supplyDetectorEnable}, 8'h00);
		for (int a = 8; a < 17; a++) regCheck(7'(a));
		// Random legal contents; reserved codes never sent, detector kept off
		for (int k = 0; k < 4; k++) begin
			rnd = $random(seed);
			regWrite(7'h09, rnd[7:0]);
			regWrite(7'h0b, rnd[15:8]);
			regWrite(7'h0c, rnd[23:16] & 8'hf7);
			regWrite(7'h0a, rnd[7:0] & 8'h7f);
			regWrite(7'h20, rnd[31:24]); // Unmapped, must be ignored
			regWrite(7'h0d, {2'(1 + rnd[25:24] % 3), 2'(1 + rnd[27:26] % 3), rnd[28],
				2'(rnd[30:29] % 3), 1'b0});
			check("freq", carrierFreqLow, rnd[7:0]);
			check("afc", {7'h0, afcLowIndexSelect}, {7'h0, rnd[13]});
			check("trim", {5'h0, supplyThresholdTrim}, {5'h0, rnd[18:16]});
			for (int a = 9; a < 14; a++) regCheck(7'(a));
			regCheck(7'h20);
		end
		// Live detector output while enabled
		regWrite(7'h0c, 8'h0d);
		check("detEn", {7'h0, supplyDetectorEnable}, 8'h01);
		for (int v = 0; v < 2; v++) begin
			supplyDetectorOut = v[0];
			u_spi_host_model.access(1'b0, 7'h0c, 8'h00, got);
			check("lowbat live", got, 8'h0d | {3'h0, v[0], 4'h0});
		end
		supplyDetectorOut = 1'b0;
		regWrite(7'h0c, 8'h02);
		// Calibration started from standby with listen off
		check("standby", {5'h0, chipMode}, 8'h01);
		regWrite(7'h0a, 8'h80);
		u_spi_host_model.access(1'b0, 7'h0a, 8'h00, got);
		check("cal busy", got, 8'h00);
		repeat (CAL) @(negedge mclk);
		regCheck(7'h0a);
		// Listen cycling with each end action; idle 2 units, rx 3 units, base codes 01, 10 and 11 used
		regWrite(7'h0e, 8'h02);
		regWrite(7'h0f, 8'h03);
		for (int e = 0; e < 3; e++) begin
			regWrite(7'h0d, {e == 1 ? 2'b01 : 2'b10, e == 2 ? 2'b11 : 2'b10, e == 0, 2'(e),
				1'b0});
			idleUnit = e == 1 ? SHORT : MID;
			modeSelect = e == 1 ? 3'b010 : 3'b001;
			listenOn = 1'b1;
			repeat (2) @(negedge mclk);
			check("idle mode", {5'h0, chipMode}, 8'h00);
			waitMode(3'b100, 2 * idleUnit + 10, n);
			check("idle span", {7'h0, n > idleUnit && n <= 2 * idleUnit + 4}, 8'h01);
			rssiAbove = 1'b1;
			repeat (3) @(negedge mclk);
			check("stopped early", {7'h0, listenStopped}, 8'h00);
			syncAddressMatch = 1'b1;
			repeat (3) @(negedge mclk);
			check("hold rx", {5'h0, chipMode}, 8'h04);
			check("stopped", {7'h0, listenStopped}, {7'h0, e == 0});
			if (e > 0) begin
				{packetCompleteFlag, rxTimeout} = {e == 1, e == 2};
				@(negedge mclk);
				{packetCompleteFlag, rxTimeout, rssiAbove, syncAddressMatch} = 4'h0;
				repeat (3) @(negedge mclk);
				check("after end", {5'h0, chipMode}, e == 1 ? 8'h02 : 8'h00);
				check("stopped", {7'h0, listenStopped}, {7'h0, e == 1});
			end
			if (e == 2) begin
				discards = 0;
				waitMode(3'b100, 2 * MID + 10, n);
				repeat (2) @(negedge mclk);
				check("discard", 8'(discards), 8'h01);
				waitMode(3'b000, 6 * MID + 10, n);
				check("rx span", {7'h0, n > 4 * MID && n <= 6 * MID + 4}, 8'h01);
			end
			// Host ends listen mode itself
			{rssiAbove, syncAddressMatch, listenOn} = 3'h0;
			modeSelect = 3'b001;
			repeat (2) @(negedge mclk);
			check("off mode", {5'h0, chipMode}, 8'h01);
		end
		conclude();
	end
endmodule
